// ---- rtl/cso_consts.svh ----
// Offsets, field positions, reset values and encodings of the clock strap block
`ifndef CSO_CONSTS_SVH
`define CSO_CONSTS_SVH

// ==========================================
// Register byte offsets
`define CSO_ADDR_CTRL 8'h00
`define CSO_ADDR_STATUS 8'h04
`define CSO_ADDR_CPU_FREQ 8'h08
`define CSO_ADDR_BUS_FREQ 8'h0c

// ==========================================
// Control fields and reset value
`define CSO_CTRL_SIO48_BIT 0
`define CSO_CTRL_RESET 1'b1

// ==========================================
// Status fields
`define CSO_ST_CODE_LSB 0
`define CSO_ST_FAMILY_BIT 4
`define CSO_ST_DRIVE_BIT 5
`define CSO_ST_MEMTYPE_BIT 6
`define CSO_ST_CAPTURED_BIT 7
`define CSO_ST_OUTEN_BIT 8
`define CSO_ST_APPLIED_LSB 12

// ==========================================
// Strap pin indices
`define CSO_PIN_FS0 0
`define CSO_PIN_FS1 1
`define CSO_PIN_FS2 2
`define CSO_PIN_FS3 3
`define CSO_PIN_FAMILY 4
`define CSO_PIN_DRIVE 5
`define CSO_PIN_MEMTYPE 6

// ==========================================
// Bus responses
`define CSO_RESP_OKAY 2'h0
`define CSO_RESP_SLVERR 2'h2

`endif

// ---- rtl/cso_pkg.sv ----
// Types shared by the clock strap and output select block
package cso_pkg;

    // ==========================================
    // Power-up sequence
    typedef enum logic [1:0] {
        ST_STRAP,
        ST_WAIT_PG,
        ST_RUN
    } cso_state_t;

    // ==========================================
    // Synthesiser targets in units of 10 kHz
    typedef struct packed {
        logic [15:0] cpu;
        logic [15:0] agp;
        logic [15:0] pci;
    } cso_freq_t;

    // ==========================================
    // AXI4-Lite carriers
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } cso_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cso_axi_rsp_t;

endpackage

// ---- rtl/cso_top.sv ----
// Power-up strap capture, frequency selection and clock output routing
//
// Function
// - Strap pins are inputs at power-up, captured at supply threshold, then drive clocks.
// - CPU, graphics and bus frequencies come from the captured four-bit code.
// - Mode one: power-good falling latches code and drive, then enables all outputs but the reference and free-running bus clock.
// - After the first power-good fall the input is ignored for good.
// - Mode zero: power-good unused, its pin drives a second oscillator reference.
// - After capture the code bit 0 pin drives buffered oscillator reference.
// - Memory type 0: six differential pairs, true copies buffer input, complement inverts.
// - Memory type 1: all twelve memory pins single-ended, in phase with buffer input.
// - Family strap high is mode one, low mode zero; pin becomes graphics clock.
// - Mode one CPU pair push-pull true/complement; mode zero open-drain pair.
// - Drive select 0 gives 4x reference current, 1 gives 6x; pin becomes bus clock.
// - Code bit 1 pin becomes free-running bus clock; bit 3 pin becomes USB clock.
// - Bus and graphics clocks are synchronous to CPU clocks at selected rates.
// - A separate chipset clock pair follows the selected CPU frequency.
// - Code bit 2 pin becomes a programmable 24 or 48 MHz clock.
// - Memory type strap captured at power-up, pin then becomes a bus clock.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "cso_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module cso_top
    import cso_pkg::*;
#(
    parameter int MEM_PAIRS = 6,
    parameter int STRAPS = 7
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Power-up and sources
    input wire logic supply_ok,
    input wire logic osc_in,
    input wire logic buf_in,
    input wire logic pll_cpu,
    input wire logic pll_agp,
    input wire logic pll_pci,
    input wire logic pll_usb,
    // Dual-purpose strap pins
    input wire logic [STRAPS-1:0] strap_in,
    output logic [STRAPS-1:0] strap_out,
    output logic [STRAPS-1:0] strap_oe_n,
    // Power-good pin, reference clock in mode zero
    input wire logic cpu_power_good_n_in,
    output logic cpu_power_good_n_out,
    output logic cpu_power_good_n_oe_n,
    // CPU pair
    output logic cpu_clk_true,
    output logic cpu_clk_true_oe_n,
    output logic cpu_clk_comp,
    output logic cpu_clk_comp_oe_n,
    output logic cpu_drive_x6,
    output logic [1:0] chipset_cpu_clk_pair,
    // Graphics and bus clocks
    output logic graphics_port_clk,
    output logic bus_clk,
    // Memory clocks
    output logic [MEM_PAIRS-1:0] mem_clk_true,
    output logic [MEM_PAIRS-1:0] mem_clk_comp,
    // Synthesiser targets
    output cso_freq_t pll_freq,
    // Register bus
    input wire cso_axi_req_t s_axi_req,
    output cso_axi_rsp_t s_axi_rsp
);

    // ==========================================
    // Frequency table and address decode
    function automatic cso_freq_t freq_lookup(input logic [3:0] code);
        case (code)
            4'h0: freq_lookup = '{16'h1a18, 16'h1a18, 16'h0d0c};
            4'h1: freq_lookup = '{16'h2710, 16'h1a18, 16'h0d0c};
            4'h2: freq_lookup = '{16'h2ee0, 16'h1770, 16'h0bb8};
            4'h3: freq_lookup = '{16'h3415, 16'h1a0b, 16'h0d05};
            4'h4: freq_lookup = '{16'h1c20, 16'h1c20, 16'h0e10};
            4'h5: freq_lookup = '{16'h2904, 16'h1b58, 16'h0dac};
            4'h6: freq_lookup = '{16'h3e80, 16'h1900, 16'h0c80};
            4'h7: freq_lookup = '{16'h36b0, 16'h1b58, 16'h0dac};
            4'h8: freq_lookup = '{16'h1e14, 16'h1e14, 16'h0f0a};
            4'h9: freq_lookup = '{16'h2af8, 16'h1ca5, 16'h0e53};
            4'ha: freq_lookup = '{16'h4650, 16'h1770, 16'h0bb8};
            4'hb: freq_lookup = '{16'h3a98, 16'h1770, 16'h0bb8};
            4'hc: freq_lookup = '{16'h2328, 16'h1770, 16'h0bb8};
            4'hd: freq_lookup = '{16'h2710, 16'h1a0b, 16'h0d05};
            4'he: freq_lookup = '{16'h4e20, 16'h1a0b, 16'h0d05};
            default: freq_lookup = '{16'h3415, 16'h1a0b, 16'h0d05};
        endcase
    endfunction

    function automatic logic reg_known(input logic [7:0] a);
        reg_known = (a == `CSO_ADDR_CTRL) || (a == `CSO_ADDR_STATUS) ||
                    (a == `CSO_ADDR_CPU_FREQ) || (a == `CSO_ADDR_BUS_FREQ);
    endfunction

    // ==========================================
    // State
    cso_state_t state_r, state_nxt;
    logic captured_r;
    logic [3:0] strap_code_r;
    logic family_r, drive_r, memtype_r;
    logic [3:0] applied_code_r;
    logic drive_applied_r;
    logic out_en_r;
    logic pg_prev_r;
    logic usb_prev_r, sio_div_r;
    logic sio48_r;
    logic [STRAPS-1:0] strap_out_r, strap_oe_n_r;
    logic pg_out_r, pg_oe_n_r;
    logic cpu_t_r, cpu_t_oe_n_r, cpu_c_r, cpu_c_oe_n_r, cpu_drive_r;
    logic [1:0] chipset_r;
    logic gfx_r, bus_r;
    logic [MEM_PAIRS-1:0] mem_t_r, mem_c_r;
    cso_freq_t freq_r;
    cso_axi_rsp_t rsp_r;

    // ==========================================
    // Power-up sequence
    wire capture_now = (state_r == ST_STRAP) && supply_ok;
    // Previous level is parked high until capture, so a pin tied low still counts as one fall
    wire pg_fall = (state_r == ST_WAIT_PG) && pg_prev_r && !cpu_power_good_n_in;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_STRAP: if (supply_ok) state_nxt = strap_in[`CSO_PIN_FAMILY] ? ST_WAIT_PG : ST_RUN;
            ST_WAIT_PG: if (pg_fall) state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_STRAP;
            captured_r <= 1'b0;
            strap_code_r <= 4'h0;
            family_r <= 1'b0;
            drive_r <= 1'b0;
            memtype_r <= 1'b0;
            applied_code_r <= 4'h0;
            drive_applied_r <= 1'b0;
            out_en_r <= 1'b0;
            pg_prev_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            pg_prev_r <= (state_r == ST_STRAP) || cpu_power_good_n_in;
            if (capture_now) begin
                captured_r <= 1'b1;
                strap_code_r <= strap_in[`CSO_PIN_FS3:`CSO_PIN_FS0];
                family_r <= strap_in[`CSO_PIN_FAMILY];
                drive_r <= strap_in[`CSO_PIN_DRIVE];
                memtype_r <= strap_in[`CSO_PIN_MEMTYPE];
                if (!strap_in[`CSO_PIN_FAMILY]) begin
                    applied_code_r <= strap_in[`CSO_PIN_FS3:`CSO_PIN_FS0];
                    drive_applied_r <= strap_in[`CSO_PIN_DRIVE];
                    out_en_r <= 1'b1;
                end
            end
            if (pg_fall) begin
                applied_code_r <= strap_code_r;
                drive_applied_r <= drive_r;
                out_en_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // Clock routing
    // Reference and free-running bus clock do not wait for power-good
    wire sio_src = sio48_r ? pll_usb : sio_div_r;
    wire [STRAPS-1:0] strap_src = {pll_pci & out_en_r, pll_pci & out_en_r, pll_agp & out_en_r,
                                   pll_usb & out_en_r, sio_src & out_en_r, pll_pci, osc_in};
    wire cpu_g = pll_cpu & out_en_r;
    wire od_mode = !family_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            usb_prev_r <= 1'b0;
            sio_div_r <= 1'b0;
            strap_out_r <= '0;
            strap_oe_n_r <= '1;
            pg_out_r <= 1'b0;
            pg_oe_n_r <= 1'b1;
            cpu_t_r <= 1'b0;
            cpu_c_r <= 1'b0;
            cpu_t_oe_n_r <= 1'b1;
            cpu_c_oe_n_r <= 1'b1;
            cpu_drive_r <= 1'b0;
            chipset_r <= 2'h0;
            gfx_r <= 1'b0;
            bus_r <= 1'b0;
            freq_r <= '0;
        end else begin
            usb_prev_r <= pll_usb;
            if (pll_usb && !usb_prev_r) sio_div_r <= !sio_div_r;
            strap_out_r <= captured_r ? strap_src : '0;
            strap_oe_n_r <= {STRAPS{!(captured_r || capture_now)}};
            pg_out_r <= captured_r && od_mode && osc_in;
            pg_oe_n_r <= !((captured_r || capture_now) && !strap_in[`CSO_PIN_FAMILY] && state_r == ST_STRAP
                         || captured_r && od_mode);
            if (od_mode) begin
                cpu_t_r <= 1'b0;
                cpu_c_r <= 1'b0;
                cpu_t_oe_n_r <= !(out_en_r && !pll_cpu);
                cpu_c_oe_n_r <= !(out_en_r && pll_cpu);
            end else begin
                cpu_t_r <= cpu_g;
                cpu_c_r <= out_en_r & !pll_cpu;
                cpu_t_oe_n_r <= !captured_r;
                cpu_c_oe_n_r <= !captured_r;
            end
            cpu_drive_r <= drive_applied_r;
            chipset_r <= {out_en_r & !pll_cpu, cpu_g};
            gfx_r <= pll_agp & out_en_r;
            bus_r <= pll_pci & out_en_r;
            freq_r <= freq_lookup(applied_code_r);
        end
    end

    // ==========================================
    // Memory clocks
    genvar gi;
    generate
        for (gi = 0; gi < MEM_PAIRS; gi++) begin : g_mem
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    mem_t_r[gi] <= 1'b0;
                    mem_c_r[gi] <= 1'b0;
                end else begin
                    mem_t_r[gi] <= buf_in & out_en_r;
                    mem_c_r[gi] <= (memtype_r ? buf_in : !buf_in) & out_en_r;
                end
            end
        end
    endgenerate

    // ==========================================
    // Register bus
    wire [7:0] wa = s_axi_req.awaddr[7:0];
    wire [7:0] ra = s_axi_req.araddr[7:0];
    wire wr_go = s_axi_req.awvalid && s_axi_req.wvalid && !rsp_r.awready && !rsp_r.bvalid;
    wire wr_take = rsp_r.awready && s_axi_req.awvalid && s_axi_req.wvalid;
    wire ar_go = s_axi_req.arvalid && !rsp_r.arready && !rsp_r.rvalid;
    wire ar_take = rsp_r.arready && s_axi_req.arvalid;
    wire [31:0] status_w = {16'h0, applied_code_r, 3'h0, out_en_r, captured_r, memtype_r, drive_r,
                            family_r, strap_code_r};
    wire [31:0] rd_word = (ra == `CSO_ADDR_CTRL) ? {31'h0, sio48_r} :
                          (ra == `CSO_ADDR_STATUS) ? status_w :
                          (ra == `CSO_ADDR_CPU_FREQ) ? {16'h0, freq_r.cpu} :
                          (ra == `CSO_ADDR_BUS_FREQ) ? {freq_r.agp, freq_r.pci} : 32'h0;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_r <= '0;
            sio48_r <= `CSO_CTRL_RESET;
        end else begin
            rsp_r.awready <= wr_go;
            rsp_r.wready <= wr_go;
            rsp_r.arready <= ar_go;
            if (wr_take) begin
                rsp_r.bvalid <= 1'b1;
                rsp_r.bresp <= reg_known(wa) ? `CSO_RESP_OKAY : `CSO_RESP_SLVERR;
                if (wa == `CSO_ADDR_CTRL && s_axi_req.wstrb[0]) sio48_r <= s_axi_req.wdata[`CSO_CTRL_SIO48_BIT];
            end else if (rsp_r.bvalid && s_axi_req.bready) begin
                rsp_r.bvalid <= 1'b0;
            end
            if (ar_take) begin
                rsp_r.rvalid <= 1'b1;
                rsp_r.rdata <= rd_word;
                rsp_r.rresp <= reg_known(ra) ? `CSO_RESP_OKAY : `CSO_RESP_SLVERR;
            end else if (rsp_r.rvalid && s_axi_req.rready) begin
                rsp_r.rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Outputs
    assign strap_out = strap_out_r;
    assign strap_oe_n = strap_oe_n_r;
    assign cpu_power_good_n_out = pg_out_r;
    assign cpu_power_good_n_oe_n = pg_oe_n_r;
    assign cpu_clk_true = cpu_t_r;
    assign cpu_clk_true_oe_n = cpu_t_oe_n_r;
    assign cpu_clk_comp = cpu_c_r;
    assign cpu_clk_comp_oe_n = cpu_c_oe_n_r;
    assign cpu_drive_x6 = cpu_drive_r;
    assign chipset_cpu_clk_pair = chipset_r;
    assign graphics_port_clk = gfx_r;
    assign bus_clk = bus_r;
    assign mem_clk_true = mem_t_r;
    assign mem_clk_comp = mem_c_r;
    assign pll_freq = freq_r;
    assign s_axi_rsp = rsp_r;

    // ==========================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_strap_input; !captured_r && !capture_now |=> &strap_oe_n_r; endproperty
    a_strap_input: assert property (p_strap_input) else $error("strap pin driven before capture");
    property p_capture;
        capture_now |=> captured_r && !strap_oe_n_r[0] && strap_code_r == $past(strap_in[3:0]);
    endproperty
    a_capture: assert property (p_capture) else $error("strap code not captured");
    property p_freq_133; applied_code_r == 4'h3 ##1 applied_code_r == 4'h3 |-> freq_r.pci == 16'h0d05; endproperty
    a_freq_133: assert property (p_freq_133) else $error("code 0011 wrong bus rate");
    property p_freq_200; applied_code_r == 4'he |=> freq_r.cpu == 16'h4e20; endproperty
    a_freq_200: assert property (p_freq_200) else $error("code 1110 not 200 MHz");
    sequence s_pg_fall; state_r == ST_WAIT_PG && pg_prev_r && !cpu_power_good_n_in; endsequence
    property p_pg_enable; s_pg_fall |=> out_en_r && applied_code_r == strap_code_r ##1 cpu_drive_r == drive_r; endproperty
    a_pg_enable: assert property (p_pg_enable) else $error("power-good fall did not enable");
    property p_pg_ignore; state_r == ST_RUN |=> state_r == ST_RUN && $stable(applied_code_r); endproperty
    a_pg_ignore: assert property (p_pg_ignore) else $error("power-good acted after first fall");
    property p_ref_second; captured_r && od_mode |=> !pg_oe_n_r && pg_out_r == $past(osc_in); endproperty
    a_ref_second: assert property (p_ref_second) else $error("second reference wrong");
    property p_ref_first; captured_r |=> strap_out_r[`CSO_PIN_FS0] == $past(osc_in); endproperty
    a_ref_first: assert property (p_ref_first) else $error("first reference wrong");
    property p_ddr; out_en_r && !memtype_r |=> mem_clk_comp == ~mem_clk_true; endproperty
    a_ddr: assert property (p_ddr) else $error("memory pair not complementary");
    property p_sdr; out_en_r && memtype_r |=> mem_clk_comp == {MEM_PAIRS{$past(buf_in)}}; endproperty
    a_sdr: assert property (p_sdr) else $error("single-ended memory clock wrong");
    property p_cpu_od; out_en_r && od_mode |=> !cpu_t_r && cpu_t_oe_n_r == $past(pll_cpu); endproperty
    a_cpu_od: assert property (p_cpu_od) else $error("open-drain CPU pin wrong");
    property p_drive; out_en_r ##1 out_en_r |-> cpu_drive_r == drive_applied_r; endproperty
    a_drive: assert property (p_drive) else $error("drive select not applied");

endmodule

`default_nettype wire

// ---- dv/cso_far_side_model.sv ----
// Board-side model: clock sources, strap resistors and power-good wiring
`timescale 1ns/10ps
`default_nettype none

module cso_far_side_model (
    // Clock
    input wire logic ref_clk,
    // Strap pins
    input wire logic [6:0] strap_val,
    input wire logic [6:0] strap_out,
    input wire logic [6:0] strap_oe_n,
    output logic [6:0] strap_in,
    // Power-good pin
    input wire logic pg_level,
    input wire logic pg_out,
    input wire logic pg_oe_n,
    output logic pg_in,
    // Clock sources
    output logic osc_in,
    output logic buf_in,
    output logic pll_cpu,
    output logic pll_agp,
    output logic pll_pci,
    output logic pll_usb
);
    // ==========================================
    // Sources
    // Distinct patterns per source, so a swapped route cannot match by chance
    logic [3:0] phase_r = 4'h0;
    always_ff @(posedge ref_clk) begin
        phase_r <= phase_r + 4'h1;
    end
    assign osc_in = phase_r[0];
    assign buf_in = phase_r[1];
    assign pll_cpu = phase_r[0] ^ phase_r[2];
    assign pll_agp = phase_r[2];
    assign pll_pci = phase_r[3];
    assign pll_usb = phase_r[1] ^ phase_r[3];

    // ==========================================
    // Pin resolution
    // Resistor level while the pin is an input, device level once it drives
    assign strap_in = (strap_oe_n & strap_val) | (~strap_oe_n & strap_out);
    assign pg_in = pg_oe_n ? pg_level : pg_out;
endmodule

`default_nettype wire

// ---- dv/test_clock_strap_and_output_select.sv ----
// Self-checking bench for strap capture, frequency selection and output routing
`include "cso_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module test_clock_strap_and_output_select;
    import cso_pkg::*;
    // ==========================================
    // Connections
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic supply_ok = 1'b0;
    logic pg_level = 1'b1;
    logic [6:0] strap_val = 7'h00;
    logic osc_in, buf_in, pll_cpu, pll_agp, pll_pci, pll_usb;
    logic [6:0] strap_in, strap_out, strap_oe_n;
    logic pg_in, pg_out, pg_oe_n;
    logic cpu_t, cpu_t_oe_n, cpu_c, cpu_c_oe_n, drive_x6, agp_clk, pci_clk;
    logic [1:0] cs_pair;
    logic [5:0] mem_t, mem_c;
    cso_freq_t freq;
    cso_axi_req_t req = '0;
    cso_axi_rsp_t rsp;
    int err_total = 0;
    int tests_run = 0;
    int cpu_tbl[16] = '{6680, 10000, 12000, 13333, 7200, 10500, 16000, 14000,
                        7700, 11000, 18000, 15000, 9000, 10000, 20000, 13333};
    int agp_tbl[16] = '{6680, 6680, 6000, 6667, 7200, 7000, 6400, 7000,
                        7700, 7333, 6000, 6000, 6000, 6667, 6667, 6667};
    int pci_tbl[16] = '{3340, 3340, 3000, 3333, 3600, 3500, 3200, 3500,
                        3850, 3667, 3000, 3000, 3000, 3333, 3333, 3333};

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    cso_top #(.MEM_PAIRS(6), .STRAPS(7)) cso_top_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .supply_ok(supply_ok), .osc_in(osc_in), .buf_in(buf_in),
        .pll_cpu(pll_cpu), .pll_agp(pll_agp), .pll_pci(pll_pci), .pll_usb(pll_usb),
        .strap_in(strap_in), .strap_out(strap_out), .strap_oe_n(strap_oe_n),
        .cpu_power_good_n_in(pg_in), .cpu_power_good_n_out(pg_out), .cpu_power_good_n_oe_n(pg_oe_n),
        .cpu_clk_true(cpu_t), .cpu_clk_true_oe_n(cpu_t_oe_n), .cpu_clk_comp(cpu_c),
        .cpu_clk_comp_oe_n(cpu_c_oe_n), .cpu_drive_x6(drive_x6), .chipset_cpu_clk_pair(cs_pair),
        .graphics_port_clk(agp_clk), .bus_clk(pci_clk), .mem_clk_true(mem_t), .mem_clk_comp(mem_c),
        .pll_freq(freq), .s_axi_req(req), .s_axi_rsp(rsp));

    cso_far_side_model cso_far_side_model_i (
        .ref_clk(ref_clk), .strap_val(strap_val), .strap_out(strap_out), .strap_oe_n(strap_oe_n),
        .strap_in(strap_in), .pg_level(pg_level), .pg_out(pg_out), .pg_oe_n(pg_oe_n), .pg_in(pg_in),
        .osc_in(osc_in), .buf_in(buf_in), .pll_cpu(pll_cpu), .pll_agp(pll_agp), .pll_pci(pll_pci),
        .pll_usb(pll_usb));

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 40);
        r = rsp.bresp;
        req.bready <= 1'b0;
        chk(n < 40, 1'b1);
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 40);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        chk(n < 40, 1'b1);
    endtask

    // Straps: [6] memory type, [5] drive, [4] family, [3:0] code
    task automatic power_up(input logic [6:0] straps, input logic pg);
        arst_n <= 1'b0;
        supply_ok <= 1'b0;
        pg_level <= pg;
        strap_val <= straps;
        req <= '0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(strap_oe_n, 7'h7f);
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(strap_oe_n, 7'h00);
    endtask

    // Outputs lag their sources by one cycle, so compare against the previous sample
    task automatic check_clocks(input logic en, input logic fam, input logic mem);
        logic [5:0] p;
        @(negedge ref_clk);
        p = {osc_in, buf_in, pll_cpu, pll_agp, pll_pci, pll_usb};
        repeat (16) begin
            @(negedge ref_clk);
            chk(strap_out, {{2{p[1] & en}}, p[2] & en, {2{p[0] & en}}, p[1], p[5]});
            chk({agp_clk, pci_clk, cs_pair}, {p[2] & en, p[1] & en, ~p[3] & en, p[3] & en});
            chk({mem_t, mem_c}, {{6{p[4] & en}}, {6{(mem ? p[4] : ~p[4]) & en}}});
            if (fam) begin
                chk({cpu_t, cpu_c, cpu_t_oe_n, cpu_c_oe_n, pg_oe_n}, {p[3] & en, ~p[3] & en, 3'h1});
            end else begin
                chk({cpu_t, cpu_c, cpu_t_oe_n, cpu_c_oe_n, pg_oe_n, pg_out},
                    {2'h0, ~(en & ~p[3]), ~(en & p[3]), 1'b0, p[5]});
            end
            p = {osc_in, buf_in, pll_cpu, pll_agp, pll_pci, pll_usb};
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic sweep_codes;
        for (int c = 0; c < 16; c++) begin
            power_up({3'h0, 4'(c)}, 1'b1);
            repeat (3) @(negedge ref_clk);
            chk({freq.cpu, freq.agp, freq.pci}, {cpu_tbl[c][15:0], agp_tbl[c][15:0], pci_tbl[c][15:0]});
            chk(drive_x6, 1'b0);
        end
    endtask

    task automatic mode_zero_run;
        logic [31:0] d;
        logic [1:0] r;
        power_up(7'h23, 1'b1);
        @(posedge ref_clk);
        supply_ok <= 1'b0;
        check_clocks(1'b1, 1'b0, 1'b0);
        chk(drive_x6, 1'b1);
        axi_read({24'h0, `CSO_ADDR_STATUS}, d, r);
        chk({r, d[15:12], d[8:0]}, {`CSO_RESP_OKAY, 4'h3, 9'h1a3});
    endtask

    // Power-good tied low from power-up counts as the first fall
    task automatic pg_tied_low;
        power_up(7'h13, 1'b0);
        check_clocks(1'b1, 1'b1, 1'b0);
        chk({freq.cpu, freq.pci, drive_x6}, {16'h3415, 16'h0d05, 1'b0});
    endtask

    task automatic mode_one_run;
        power_up(7'h7e, 1'b1);
        check_clocks(1'b0, 1'b1, 1'b1);
        @(posedge ref_clk);
        pg_level <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check_clocks(1'b1, 1'b1, 1'b1);
        chk({freq.cpu, freq.agp, freq.pci, drive_x6}, {16'h4e20, 16'h1a0b, 16'h0d05, 1'b1});
        @(posedge ref_clk);
        pg_level <= 1'b1;
        check_clocks(1'b1, 1'b1, 1'b1);
        chk({freq.cpu, drive_x6}, {16'h4e20, 1'b1});
    endtask

    task automatic reg_access;
        logic [31:0] d;
        logic [1:0] r;
        int k;
        logic q;
        axi_read({24'h0, `CSO_ADDR_CTRL}, d, r);
        chk({r, d}, {`CSO_RESP_OKAY, 32'h1});
        axi_write({24'h0, `CSO_ADDR_CTRL}, 32'h0, 4'h0, r);
        axi_read({24'h0, `CSO_ADDR_CTRL}, d, r);
        chk({r, d}, {`CSO_RESP_OKAY, 32'h1});
        axi_write({24'h0, `CSO_ADDR_CTRL}, 32'h0, 4'hf, r);
        axi_read({24'h0, `CSO_ADDR_CTRL}, d, r);
        chk({r, d}, {`CSO_RESP_OKAY, 32'h0});
        // Source rises 3 times per 16 cycles, so the halved clock changes 3 times (48 MHz mode: 6)
        @(negedge ref_clk);
        q = strap_out[2];
        k = 0;
        repeat (16) begin
            @(negedge ref_clk);
            if (strap_out[2] !== q) k++;
            q = strap_out[2];
        end
        chk(k, 3);
        axi_write(32'h10, 32'h1, 4'hf, r);
        chk(r, `CSO_RESP_SLVERR);
        axi_read(32'h10, d, r);
        chk({r, d}, {`CSO_RESP_SLVERR, 32'h0});
        axi_read({24'h0, `CSO_ADDR_CPU_FREQ}, d, r);
        chk({r, d}, {`CSO_RESP_OKAY, 32'h4e20});
        axi_read({24'h0, `CSO_ADDR_BUS_FREQ}, d, r);
        chk({r, d}, {`CSO_RESP_OKAY, 16'h1a0b, 16'h0d05});
    endtask

    // ==========================================
    // Sequence and watchdog
    initial begin
        sweep_codes();
        mode_zero_run();
        pg_tied_low();
        mode_one_run();
        reg_access();
        report_and_stop();
    end

    // Whole run is a few hundred cycles; this span leaves a wide margin
    initial begin
        #100us;
        err_total++;
        report_and_stop();
    end
endmodule

`default_nettype wire
